// ==== rtl/scs_regs.svh ====
// Register offsets, field positions, reset values and limits of the contact-stop selector.
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH

// Register byte offsets.
`define SCS_ADDR_CONTACT_SEL   8'h00
`define SCS_ADDR_OPMODE        8'h04
`define SCS_ADDR_REMOTE        8'h08
`define SCS_ADDR_PROCLOOP      8'h0c
`define SCS_ADDR_AUTORAMP      8'h10
`define SCS_ADDR_HIGH          8'h14
`define SCS_ADDR_MIDDLE        8'h18
`define SCS_ADDR_LOW           8'h1c
`define SCS_ADDR_INCH          8'h20
`define SCS_ADDR_SPEED4        8'h24
`define SCS_ADDR_SPEED5        8'h28
`define SCS_ADDR_SPEED6        8'h2c
`define SCS_ADDR_SPEED7        8'h30
`define SCS_ADDR_STALL1        8'h34
`define SCS_ADDR_STALL2        8'h38
`define SCS_ADDR_EXCITE        8'h3c
`define SCS_ADDR_CCARRIER      8'h40
`define SCS_ADDR_NCARRIER      8'h44
`define SCS_ADDR_WRITESEL      8'h48
`define SCS_ADDR_STATUS        8'h4c
`define SCS_ADDR_FREQ          8'h50

// Status register field positions.
`define SCS_STAT_ACTIVE        0
`define SCS_STAT_ALLOWED       1
`define SCS_STAT_INPUTS_LSB    2
`define SCS_STAT_SOURCE_LSB    8

// Sentinel and limits; frequency in 0.01 Hz, percent in 0.1 %.
`define SCS_NOT_SET            16'd9999
`define SCS_FREQ_MAX           16'd40000
`define SCS_CONTACT_FREQ_MAX   16'd3000
`define SCS_CARRIER_FREQ_MAX   16'd300
`define SCS_STALL_MAX          16'd2000
`define SCS_EXCITE_MAX         16'd3000
`define SCS_CARRIER_MAX        16'd9
`define SCS_REMOTE_MAX         2'd3

// Reset values.
`define SCS_RST_LOW            16'd1000
`define SCS_RST_HIGH           16'd6000
`define SCS_RST_MIDDLE         16'd3000
`define SCS_RST_INCH           16'd500
`define SCS_RST_SPEEDX         16'd0
`define SCS_RST_STALL1         16'd1500
`define SCS_RST_NCARRIER       16'd1

`endif

// ==== rtl/scs_pkg.sv ====
// Types shared by the contact-stop selector modules.
package scs_pkg;

   // Operation mode select values.
   typedef enum logic [2:0] {
      SCS_MODE_EXTERNAL = 3'b000,
      SCS_MODE_PANEL    = 3'b001,
      SCS_MODE_COMBINED = 3'b010,
      SCS_MODE_NETWORK  = 3'b011
   } scs_opmode_t;

   // Where the commanded frequency comes from.
   typedef enum logic [3:0] {
      SCS_SRC_ANALOG  = 4'b0000,
      SCS_SRC_HIGH    = 4'b0001,
      SCS_SRC_MIDDLE  = 4'b0010,
      SCS_SRC_LOW     = 4'b0011,
      SCS_SRC_SPEED4  = 4'b0100,
      SCS_SRC_SPEED5  = 4'b0101,
      SCS_SRC_SPEED6  = 4'b0110,
      SCS_SRC_SPEED7  = 4'b0111,
      SCS_SRC_INCH    = 4'b1000,
      SCS_SRC_CONTACT = 4'b1001
   } scs_source_t;

endpackage

// ==== rtl/scs_sel_if.sv ====
// Interface carrying the filtered contact inputs between selector modules.
`timescale 1ns/1ps
`default_nettype none
interface scs_sel_if;
   logic highSel;
   logic middleSel;
   logic lowSel;
   logic secondSel;
   logic jogSel;

   // Filter side drives, selector side reads.
   modport src (output highSel, middleSel, lowSel, secondSel, jogSel);
   modport dst (input highSel, middleSel, lowSel, secondSel, jogSel);
endinterface
`default_nettype wire

// ==== rtl/scs_input_filter.sv ====
// Three-flop synchroniser and agreement filter for the five contact inputs.
`timescale 1ns/1ps
`default_nettype none
module scs_input_filter (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Raw contact inputs: high, middle, low, second, jog.
   input wire logic [4:0] rawIn,
   // Filtered inputs.
   scs_sel_if.src sel
);
   logic [4:0] stage1_r;
   logic [4:0] stage2_r;
   logic [4:0] stage3_r;
   logic [4:0] clean_r;

   // Each bit only changes once the second and third stages agree.
   genvar i;
   generate
      for (i = 0; i < 5; i = i + 1) begin : g_bit
         always_ff @(posedge clock) begin
            if (rst) begin
               stage1_r[i] <= 1'b0;
               stage2_r[i] <= 1'b0;
               stage3_r[i] <= 1'b0;
               clean_r[i] <= 1'b0;
            end else begin
               stage1_r[i] <= rawIn[i];
               stage2_r[i] <= stage1_r[i];
               stage3_r[i] <= stage2_r[i];
               if (stage2_r[i] == stage3_r[i]) begin
                  clean_r[i] <= stage3_r[i];
               end
            end
         end
      end
   endgenerate

   // Fan out to the named fields.
   assign sel.highSel = clean_r[0];
   assign sel.middleSel = clean_r[1];
   assign sel.lowSel = clean_r[2];
   assign sel.secondSel = clean_r[3];
   assign sel.jogSel = clean_r[4];
endmodule
`default_nettype wire

// ==== rtl/scs_speed_select.sv ====
// Combinational frequency-source decode from the filtered select inputs.
`timescale 1ns/1ps
`default_nettype none
`include "scs_regs.svh"
module scs_speed_select (
   // Filtered inputs.
   scs_sel_if.dst sel,
   // Contact-stop condition from the top.
   input wire logic contactOn,
   // Chosen source.
   output var scs_pkg::scs_source_t source
);
   logic [2:0] multi;

   assign multi = {sel.highSel, sel.middleSel, sel.lowSel};

   // Jog first, then contact stop, then multi-speed, otherwise analog.
   always_comb begin
      if (sel.jogSel) begin
         source = scs_pkg::SCS_SRC_INCH;
      end else if (contactOn) begin
         source = scs_pkg::SCS_SRC_CONTACT;
      end else begin
         case (multi)
            3'b100: source = scs_pkg::SCS_SRC_HIGH;
            3'b010: source = scs_pkg::SCS_SRC_MIDDLE;
            3'b001: source = scs_pkg::SCS_SRC_LOW;
            3'b110: source = scs_pkg::SCS_SRC_SPEED6;
            3'b101: source = scs_pkg::SCS_SRC_SPEED5;
            3'b011: source = scs_pkg::SCS_SRC_SPEED4;
            3'b111: source = scs_pkg::SCS_SRC_SPEED7;
            default: source = scs_pkg::SCS_SRC_ANALOG;
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== rtl/scs_contact_stop.sv ====
// Stop-on-contact mode decision, parameter registers and speed-source selection.
`timescale 1ns/1ps
`default_nettype none
`include "scs_regs.svh"
// Notes on behaviour
// - Contact-stop select 0 is normal operation, 1 enables stop-on-contact.
// - Enabled, low plus second select on enters contact stop in any order.
// - Contact stop runs the low-speed preset, ignoring the earlier command.
// - A low-speed preset above 30 Hz is clamped to 30 Hz in contact stop.
// - Low-speed preset accepts 0 to 400 Hz and resets to 10 Hz.
// - Contact stop uses second stall limit unless 9999; otherwise primary limit.
// - Excitation factor applies only in contact stop; 9999 means no compensation.
// - Contact carrier used in contact stop at 3 Hz or less, unless 9999.
// - Remote speed setting values 1 to 3 disable stop-on-contact.
// - Panel, jog, combined, process loop, remote or auto ramp disable it.
// - Enabled with jog on selects the jog frequency whatever else is on.
// - Pairs select speeds 6, 5, 4; all three select speed 7.
// - A single high, middle or low select picks its preset, second allowed.
// - Only second select or nothing on takes the analog speed input.
// - Excitation factor stays writable while running with write select 0.
module scs_contact_stop (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Register port.
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdata,
   // Contact inputs from the terminals.
   input wire logic highSpeedSelectIn,
   input wire logic middleSpeedSelectIn,
   input wire logic lowSpeedSelectIn,
   input wire logic secondFunctionSelectIn,
   input wire logic jogSelectIn,
   // Motor-control side.
   input wire logic motorRunning,
   input wire logic [15:0] analogSpeed,
   input wire logic [15:0] outputFreq,
   // Selected settings.
   output logic [15:0] freqCommand,
   output logic [15:0] stallLevel,
   output logic [15:0] excitationFactor,
   output logic excitationApply,
   output logic [15:0] carrierSelect,
   output logic contactActive
);
   scs_sel_if sel ();

   logic contactStopSelect_r;
   logic [2:0] operationModeSelect_r;
   logic [1:0] remoteSpeedSelect_r;
   logic processLoopSelect_r;
   logic [3:0] autoRampSelect_r;
   logic [15:0] highSpeedPreset_r;
   logic [15:0] middleSpeedPreset_r;
   logic [15:0] lowSpeedPreset_r;
   logic [15:0] inchRunFrequency_r;
   logic [15:0] speed4Preset_r;
   logic [15:0] speed5Preset_r;
   logic [15:0] speed6Preset_r;
   logic [15:0] speed7Preset_r;
   logic [15:0] primaryStallLimit_r;
   logic [15:0] secondStallLimit_r;
   logic [15:0] contactExcitationFactor_r;
   logic [15:0] contactCarrierSelect_r;
   logic [15:0] normalCarrierSelect_r;
   logic [1:0] parameterWriteSelect_r;
   logic contactActive_r;
   logic [15:0] freqCommand_r;
   logic [15:0] stallLevel_r;
   logic excitationApply_r;
   logic [15:0] carrierSelect_r;
   logic [31:0] regRdata_r;
   logic [3:0] source_r;
   scs_pkg::scs_source_t source;

   // Raw contact levels in filter order {jog, second, low, middle, high}.
   wire [4:0] rawSel = {jogSelectIn, secondFunctionSelectIn, lowSpeedSelectIn,
                        middleSpeedSelectIn, highSpeedSelectIn};

   // Filtered contact inputs; the filter costs four clocks but rejects one-clock contact bounce.
   scs_input_filter u_filter (
      .clock(clock),
      .rst(rst),
      .rawIn(rawSel),
      .sel(sel)
   );

   // Modes under which stop-on-contact is refused.
   wire modeBlocks = (operationModeSelect_r == scs_pkg::SCS_MODE_PANEL) ||
                     (operationModeSelect_r == scs_pkg::SCS_MODE_COMBINED);
   wire remoteBlocks = (remoteSpeedSelect_r != 2'd0);
   wire contactAllowed = contactStopSelect_r && !modeBlocks && !remoteBlocks &&
                         !processLoopSelect_r && (autoRampSelect_r == 4'h0) && !sel.jogSel;
   wire contactNxt = contactAllowed && sel.lowSel && sel.secondSel;

   // Frequency-source decode.
   scs_speed_select u_select (
      .sel(sel),
      .contactOn(contactNxt),
      .source(source)
   );

   // Contact-stop frequency, clamped to the ceiling.
   wire [15:0] contactFreq = (lowSpeedPreset_r > `SCS_CONTACT_FREQ_MAX) ? `SCS_CONTACT_FREQ_MAX :
                             lowSpeedPreset_r;

   // Source to frequency value.
   logic [15:0] freqNxt;
   always_comb begin
      case (source)
         scs_pkg::SCS_SRC_HIGH: freqNxt = highSpeedPreset_r;
         scs_pkg::SCS_SRC_MIDDLE: freqNxt = middleSpeedPreset_r;
         scs_pkg::SCS_SRC_LOW: freqNxt = lowSpeedPreset_r;
         scs_pkg::SCS_SRC_SPEED4: freqNxt = speed4Preset_r;
         scs_pkg::SCS_SRC_SPEED5: freqNxt = speed5Preset_r;
         scs_pkg::SCS_SRC_SPEED6: freqNxt = speed6Preset_r;
         scs_pkg::SCS_SRC_SPEED7: freqNxt = speed7Preset_r;
         scs_pkg::SCS_SRC_INCH: freqNxt = inchRunFrequency_r;
         scs_pkg::SCS_SRC_CONTACT: freqNxt = contactFreq;
         default: freqNxt = analogSpeed;
      endcase
   end

   // Stall level, excitation and carrier choice.
   wire [15:0] stallNxt = (contactNxt && secondStallLimit_r != `SCS_NOT_SET) ? secondStallLimit_r :
                          primaryStallLimit_r;
   wire useContactCarrier = contactNxt && (outputFreq <= `SCS_CARRIER_FREQ_MAX) &&
                            (contactCarrierSelect_r != `SCS_NOT_SET);
   // The carrier follows the measured output frequency, so it may switch within one contact stop.
   wire [15:0] carrierNxt = useContactCarrier ? contactCarrierSelect_r : normalCarrierSelect_r;

   // Write gating: select 0 allows writes only when stopped (the excitation factor also while running), 1 blocks, 2 always allows.
   wire writeBlocked = (parameterWriteSelect_r == 2'd1) || (parameterWriteSelect_r == 2'd0 && motorRunning);
   wire wrOk = regWrite && !writeBlocked;
   wire [15:0] wdat = regWdata[15:0];
   wire freqOk = (wdat <= `SCS_FREQ_MAX);
   wire stall2Ok = (wdat <= `SCS_STALL_MAX) || (wdat == `SCS_NOT_SET);
   wire exciteOk = (wdat <= `SCS_EXCITE_MAX) || (wdat == `SCS_NOT_SET);
   wire carrierOk = (wdat <= `SCS_CARRIER_MAX);
   wire ccarrierOk = carrierOk || (wdat == `SCS_NOT_SET);
   wire exciteWr = regWrite && (regAddr == `SCS_ADDR_EXCITE) && exciteOk &&
                   (parameterWriteSelect_r != 2'd1);

   // Judge the factor that the register holds after this edge, so that a write of 9999
   // during contact stop never leaves the apply flag high beside a no-compensation value.
   wire [15:0] exciteFactorNxt = exciteWr ? wdat : contactExcitationFactor_r;
   wire exciteNxt = contactNxt && (exciteFactorNxt != `SCS_NOT_SET);

   // Mode and configuration registers.
   always_ff @(posedge clock) begin
      if (rst) begin
         contactStopSelect_r <= 1'b0;
         operationModeSelect_r <= scs_pkg::SCS_MODE_EXTERNAL;
         remoteSpeedSelect_r <= 2'd0;
         processLoopSelect_r <= 1'b0;
         autoRampSelect_r <= 4'h0;
         parameterWriteSelect_r <= 2'd0;
      end else begin
         if (wrOk) begin
            case (regAddr)
               `SCS_ADDR_CONTACT_SEL: contactStopSelect_r <= regWdata[0];
               `SCS_ADDR_OPMODE: operationModeSelect_r <= regWdata[2:0];
               `SCS_ADDR_REMOTE: remoteSpeedSelect_r <= regWdata[1:0];
               `SCS_ADDR_PROCLOOP: processLoopSelect_r <= regWdata[0];
               `SCS_ADDR_AUTORAMP: autoRampSelect_r <= regWdata[3:0];
               default: ;
            endcase
         end
         // The write-select register must stay writable, or a setting of 1 would lock the block for good.
         if (regWrite && regAddr == `SCS_ADDR_WRITESEL) begin
            parameterWriteSelect_r <= regWdata[1:0];
         end
      end
   end

   // Frequency presets; out-of-range writes are ignored.
   // A refused write leaves the old value in place rather than clamping it.
   always_ff @(posedge clock) begin
      if (rst) begin
         highSpeedPreset_r <= `SCS_RST_HIGH;
         middleSpeedPreset_r <= `SCS_RST_MIDDLE;
         lowSpeedPreset_r <= `SCS_RST_LOW;
         inchRunFrequency_r <= `SCS_RST_INCH;
         speed4Preset_r <= `SCS_RST_SPEEDX;
         speed5Preset_r <= `SCS_RST_SPEEDX;
         speed6Preset_r <= `SCS_RST_SPEEDX;
         speed7Preset_r <= `SCS_RST_SPEEDX;
      end else if (wrOk && freqOk) begin
         case (regAddr)
            `SCS_ADDR_HIGH: highSpeedPreset_r <= wdat;
            `SCS_ADDR_MIDDLE: middleSpeedPreset_r <= wdat;
            `SCS_ADDR_LOW: lowSpeedPreset_r <= wdat;
            `SCS_ADDR_INCH: inchRunFrequency_r <= wdat;
            `SCS_ADDR_SPEED4: speed4Preset_r <= wdat;
            `SCS_ADDR_SPEED5: speed5Preset_r <= wdat;
            `SCS_ADDR_SPEED6: speed6Preset_r <= wdat;
            `SCS_ADDR_SPEED7: speed7Preset_r <= wdat;
            default: ;
         endcase
      end
   end

   // Stall, excitation and carrier settings.
   always_ff @(posedge clock) begin
      if (rst) begin
         primaryStallLimit_r <= `SCS_RST_STALL1;
         secondStallLimit_r <= `SCS_NOT_SET;
         contactExcitationFactor_r <= `SCS_NOT_SET;
         contactCarrierSelect_r <= `SCS_NOT_SET;
         normalCarrierSelect_r <= `SCS_RST_NCARRIER;
      end else begin
         if (wrOk && regAddr == `SCS_ADDR_STALL1 && wdat <= `SCS_STALL_MAX) begin
            primaryStallLimit_r <= wdat;
         end
         if (wrOk && regAddr == `SCS_ADDR_STALL2 && stall2Ok) begin
            secondStallLimit_r <= wdat;
         end
         if (exciteWr) begin
            contactExcitationFactor_r <= wdat;
         end
         if (wrOk && regAddr == `SCS_ADDR_CCARRIER && ccarrierOk) begin
            contactCarrierSelect_r <= wdat;
         end
         if (wrOk && regAddr == `SCS_ADDR_NCARRIER && carrierOk) begin
            normalCarrierSelect_r <= wdat;
         end
      end
   end

   // Registered selection outputs; contact stop follows the inputs each clock.
   always_ff @(posedge clock) begin
      if (rst) begin
         contactActive_r <= 1'b0;
         freqCommand_r <= 16'h0000;
         stallLevel_r <= `SCS_RST_STALL1;
         excitationApply_r <= 1'b0;
         carrierSelect_r <= `SCS_RST_NCARRIER;
         source_r <= 4'h0;
      end else begin
         contactActive_r <= contactNxt;
         freqCommand_r <= freqNxt;
         stallLevel_r <= stallNxt;
         excitationApply_r <= exciteNxt;
         carrierSelect_r <= carrierNxt;
         source_r <= source;
      end
   end

   // Read multiplexer; unmapped addresses read zero.
   // Status word: bit 0 contact stop active, bit 1 contact stop allowed,
   // bits 6:2 filtered {jog, second, low, middle, high}, bits 11:8 source code.
   logic [31:0] rdNxt;
   wire [4:0] selBits = {sel.jogSel, sel.secondSel, sel.lowSel, sel.middleSel, sel.highSel};
   always_comb begin
      case (regAddr)
         `SCS_ADDR_CONTACT_SEL: rdNxt = {31'h0, contactStopSelect_r};
         `SCS_ADDR_OPMODE: rdNxt = {29'h0, operationModeSelect_r};
         `SCS_ADDR_REMOTE: rdNxt = {30'h0, remoteSpeedSelect_r};
         `SCS_ADDR_PROCLOOP: rdNxt = {31'h0, processLoopSelect_r};
         `SCS_ADDR_AUTORAMP: rdNxt = {28'h0, autoRampSelect_r};
         `SCS_ADDR_HIGH: rdNxt = {16'h0, highSpeedPreset_r};
         `SCS_ADDR_MIDDLE: rdNxt = {16'h0, middleSpeedPreset_r};
         `SCS_ADDR_LOW: rdNxt = {16'h0, lowSpeedPreset_r};
         `SCS_ADDR_INCH: rdNxt = {16'h0, inchRunFrequency_r};
         `SCS_ADDR_SPEED4: rdNxt = {16'h0, speed4Preset_r};
         `SCS_ADDR_SPEED5: rdNxt = {16'h0, speed5Preset_r};
         `SCS_ADDR_SPEED6: rdNxt = {16'h0, speed6Preset_r};
         `SCS_ADDR_SPEED7: rdNxt = {16'h0, speed7Preset_r};
         `SCS_ADDR_STALL1: rdNxt = {16'h0, primaryStallLimit_r};
         `SCS_ADDR_STALL2: rdNxt = {16'h0, secondStallLimit_r};
         `SCS_ADDR_EXCITE: rdNxt = {16'h0, contactExcitationFactor_r};
         `SCS_ADDR_CCARRIER: rdNxt = {16'h0, contactCarrierSelect_r};
         `SCS_ADDR_NCARRIER: rdNxt = {16'h0, normalCarrierSelect_r};
         `SCS_ADDR_WRITESEL: rdNxt = {30'h0, parameterWriteSelect_r};
         `SCS_ADDR_STATUS: rdNxt = {20'h0, source_r, 1'b0, selBits, contactAllowed, contactActive_r};
         `SCS_ADDR_FREQ: rdNxt = {16'h0, freqCommand_r};
         default: rdNxt = 32'h0000_0000;
      endcase
   end

   // Read data stands only in the cycle after the read strobe.
   always_ff @(posedge clock) begin
      if (rst) begin
         regRdata_r <= 32'h0000_0000;
      end else begin
         regRdata_r <= regRead ? rdNxt : 32'h0000_0000;
      end
   end

   // Outputs straight from flops.
   assign regRdata = regRdata_r;
   assign freqCommand = freqCommand_r;
   assign stallLevel = stallLevel_r;
   assign excitationFactor = contactExcitationFactor_r;
   assign excitationApply = excitationApply_r;
   assign carrierSelect = carrierSelect_r;
   assign contactActive = contactActive_r;
endmodule
`default_nettype wire

// ==== test/scs_contact_stop_chk.sv ====
// Concurrent checks on the ports of the contact-stop selector.
`timescale 1ns/1ps
`default_nettype none
module scs_contact_stop_chk (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Register port.
   input wire logic regRead,
   input wire logic [31:0] regRdata,
   // Contact inputs.
   input wire logic lowSpeedSelectIn,
   input wire logic secondFunctionSelectIn,
   input wire logic jogSelectIn,
   // Selected settings.
   input wire logic [15:0] freqCommand,
   input wire logic [15:0] excitationFactor,
   input wire logic excitationApply,
   input wire logic [15:0] carrierSelect,
   input wire logic contactActive
);
   // All checks run on the rising edge; all but a_reset_state pause while reset is held.
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   a_reset_state: assert property (disable iff (1'b0) rst |=>
      (regRdata == 32'h0 && freqCommand == 16'h0 && !contactActive && !excitationApply))
      else $error("outputs not at their reset values");
   a_read_idle: assert property (!regRead |=> regRdata == 32'h0)
      else $error("read data present without a read");
   a_jog_blocks: assert property (jogSelectIn [*6] |-> !contactActive)
      else $error("contact stop active with jog held on");
   a_low_exit: assert property (!lowSpeedSelectIn [*6] |-> !contactActive)
      else $error("contact stop held after low select dropped");
   a_second_exit: assert property (!secondFunctionSelectIn [*6] |-> !contactActive)
      else $error("contact stop held after second select dropped");
   a_apply_contact: assert property (excitationApply |->
      (contactActive && excitationFactor != 16'h270f && excitationFactor <= 16'h0bb8))
      else $error("excitation applied outside contact stop");
   a_freq_clamp: assert property (contactActive |-> freqCommand <= 16'h0bb8)
      else $error("contact-stop frequency above the clamp");
   a_carrier_range: assert property (carrierSelect <= 16'h0009)
      else $error("carrier setting out of range");
endmodule
bind scs_contact_stop scs_contact_stop_chk scs_contact_stop_chk_inst (.clock(clock), .rst(rst),
   .regRead(regRead), .regRdata(regRdata), .lowSpeedSelectIn(lowSpeedSelectIn),
   .secondFunctionSelectIn(secondFunctionSelectIn), .jogSelectIn(jogSelectIn),
   .freqCommand(freqCommand), .excitationFactor(excitationFactor), .excitationApply(excitationApply),
   .carrierSelect(carrierSelect), .contactActive(contactActive));
`default_nettype wire

// ==== test/scs_switch_model.sv ====
// Behavioural model of the switches or controller that drive the contact inputs.
`timescale 1ns/1ps
`default_nettype none
module scs_switch_model (
   // Clock.
   input wire logic clock,
   // Wanted levels {jog, second, low, middle, high} and pacing.
   input wire logic [4:0] want,
   input wire logic slow,
   // Contact levels.
   output logic [4:0] pins
);
   logic [4:0] lagWant_r;

   // A slow controller closes its contacts one clock later than a prompt one.
   always_ff @(posedge clock) begin
      lagWant_r <= want;
      pins <= slow ? lagWant_r : want;
   end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the contact-stop selector.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clock, rst, regWrite, regRead, motorRunning, slow;
   logic [7:0] regAddr;
   logic [31:0] regWdata, regRdata;
   logic [15:0] analogSpeed, outputFreq, freqCommand, stallLevel, excitationFactor, carrierSelect;
   logic excitationApply, contactActive;
   logic [4:0] want, pins;
   int num_errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   // Expected frequency for each {low, middle, high} pattern outside contact stop.
   logic [15:0] hml [8] = '{16'h04d2, 16'h1770, 16'h0bb8, 16'h0258, 16'h03e8, 16'h01f4, 16'h0190, 16'h02bc};
   // Settings that must block contact stop, with the blocking value.
   logic [7:0] offA [8] = '{8'h04, 8'h04, 8'h08, 8'h08, 8'h08, 8'h0c, 8'h10, 8'h00};
   logic [1:0] offV [8] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h3, 2'h1, 2'h1, 2'h0};

   scs_switch_model scs_switch_model_inst (.clock(clock), .want(want), .slow(slow), .pins(pins));
   scs_contact_stop scs_contact_stop_inst (.clock(clock), .rst(rst), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .highSpeedSelectIn(pins[0]), .middleSpeedSelectIn(pins[1]), .lowSpeedSelectIn(pins[2]),
      .secondFunctionSelectIn(pins[3]), .jogSelectIn(pins[4]), .motorRunning(motorRunning),
      .analogSpeed(analogSpeed), .outputFreq(outputFreq), .freqCommand(freqCommand),
      .stallLevel(stallLevel), .excitationFactor(excitationFactor), .excitationApply(excitationApply),
      .carrierSelect(carrierSelect), .contactActive(contactActive));

   // Free-running 50 MHz clock.
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // Prints the counts and the verdict, then stops.
   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // A hang is counted as a mismatch once the cycle ceiling is reached.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         conclude();
      end
   end

   // Compares one observed value with its expectation.
   task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Single-cycle register write.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask

   // Single-cycle register read, data compared in the following cycle.
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRead <= 1'b0;
      #1;
      chkVal(regRdata, exp);
   endtask

   // Waits some edges and lets their updates land.
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // Changes the contact levels and waits past the input filter.
   task automatic setIn(input logic [4:0] v);
      @(posedge clock);
      want <= v;
      step(9);
   endtask

   // Checks the selected settings together.
   task automatic outs(input logic [15:0] f, s, c, input logic a, p);
      chkVal(freqCommand, f);
      chkVal(stallLevel, s);
      chkVal(carrierSelect, c);
      chkVal(contactActive, a);
      chkVal(excitationApply, p);
   endtask

   // Main sequence.
   initial begin
      rst = 1'b1;
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 8'h00;
      regWdata = 32'h0;
      motorRunning = 1'b0;
      slow = 1'b0;
      analogSpeed = 16'h04d2;
      outputFreq = 16'h0064;
      want = 5'h00;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      rd(8'h00, 32'h0);
      rd(8'h1c, 32'h3e8);
      rd(8'h38, 32'h270f);
      rd(8'h3c, 32'h270f);
      rd(8'h40, 32'h270f);
      rd(8'h7c, 32'h0);
      outs(16'h04d2, 16'h05dc, 16'h0001, 1'b0, 1'b0);
      for (int i = 0; i < 4; i++) wr(8'h24 + 8'(4 * i), 32'h190 + 32'(100 * i));
      wr(8'h20, 32'hfa);
      wr(8'h00, 32'h1);
      for (int i = 0; i < 8; i++) begin
         setIn(5'(i));
         chkVal(freqCommand, hml[i]);
      end
      slow = 1'b1;
      for (int i = 0; i < 4; i++) begin
         setIn(5'h08 + 5'(i));
         chkVal(freqCommand, hml[i]);
      end
      setIn(5'h08);
      setIn(5'h0d);
      outs(16'h03e8, 16'h05dc, 16'h0001, 1'b1, 1'b0);
      wr(8'h38, 32'h320);
      wr(8'h3c, 32'h5dc);
      wr(8'h40, 32'h5);
      @(posedge clock);
      outputFreq <= 16'h012c;
      step(2);
      outs(16'h03e8, 16'h0320, 16'h0005, 1'b1, 1'b1);
      chkVal(excitationFactor, 16'h05dc);
      @(posedge clock);
      outputFreq <= 16'h012d;
      step(2);
      chkVal(carrierSelect, 16'h0001);
      wr(8'h1c, 32'hbb9);
      step(1);
      chkVal(freqCommand, 16'h0bb8);
      wr(8'h1c, 32'hc8);
      wr(8'h1c, 32'h9c41);
      rd(8'h1c, 32'hc8);
      @(posedge clock);
      motorRunning <= 1'b1;
      wr(8'h3c, 32'h640);
      rd(8'h3c, 32'h640);
      wr(8'h1c, 32'h64);
      rd(8'h1c, 32'hc8);
      wr(8'h3c, 32'h270f);
      step(1);
      chkVal(excitationApply, 1'b0);
      @(posedge clock);
      motorRunning <= 1'b0;
      wr(8'h48, 32'h1);
      rd(8'h48, 32'h1);
      wr(8'h3c, 32'h3e8);
      rd(8'h3c, 32'h270f);
      wr(8'h48, 32'h0);
      for (int i = 0; i < 8; i++) begin
         wr(offA[i], {30'h0, offV[i]});
         step(1);
         chkVal(contactActive, 1'b0);
         wr(offA[i], (offA[i] == 8'h00) ? 32'h1 : 32'h0);
         step(1);
         chkVal(contactActive, 1'b1);
      end
      setIn(5'h1d);
      chkVal(freqCommand, 16'h00fa);
      chkVal(contactActive, 1'b0);
      setIn(5'h0d);
      chkVal(freqCommand, 16'h00c8);
      setIn(5'h05);
      outs(16'h01f4, 16'h05dc, 16'h0001, 1'b0, 1'b0);
      slow = 1'b0;
      setIn(5'h04);
      setIn(5'h0c);
      chkVal(contactActive, 1'b1);
      setIn(5'h08);
      outs(16'h04d2, 16'h05dc, 16'h0001, 1'b0, 1'b0);
      rd(8'h4c, 32'h22);
      rd(8'h50, 32'h4d2);
      conclude();
   end
endmodule
`default_nettype wire
